// *** hdl/bao_core.sv ***
// Next program counter formation and implied/register operand handling.
// Assumes decode holds instr_valid for one cycle per instruction and memory answers reads with mem_rd_valid.
`timescale 1ns/1ps
`default_nettype none
module bao_core (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              instr_valid,
  input  wire bao_pkg::bao_op_type op_kind,
  input  wire logic [2:0]        instr_len,
  input  wire logic [7:0]        opcode_byte,
  input  wire logic [7:0]        rel_displacement,
  input  wire logic [15:0]       imm16,
  input  wire logic [10:0]       eleven_bit_target,
  input  wire logic              cond_true,
  input  wire logic [2:0]        reg_code,
  input  wire logic [7:0]        reg_wr_data,
  input  wire logic              bank_select_flag_low,
  input  wire logic              bank_select_flag_high,
  input  wire logic              carry_flag,
  input  wire logic              aux_carry_flag,
  input  wire logic [7:0]        mem_operand,
  output logic      [15:0]       pc_q,
  output logic                   busy_q,
  output logic                   done_q,
  output logic                   push_ret_q,
  output logic      [15:0]       ret_addr_q,
  output logic                   mem_rd_req_q,
  output logic      [15:0]       mem_addr_q,
  input  wire logic              mem_rd_valid,
  input  wire logic [7:0]        mem_rd_data,
  output logic                   mem_wr_en_q,
  output logic      [7:0]        mem_wr_data_q,
  output logic      [7:0]        reg_rd_q,
  output logic      [15:0]       pair_rd_q,
  output logic                   carry_out_q
);

  bao_pkg::bao_state_type st_q;
  bao_pkg::bao_state_type st_d;

  logic [15:0] pc_d;
  logic        busy_d;
  logic        done_d;
  logic        push_ret_d;
  logic [15:0] ret_addr_d;
  logic        mem_rd_req_d;
  logic [15:0] mem_addr_d;
  logic        mem_wr_en_d;
  logic [7:0]  mem_wr_data_d;
  logic [7:0]  reg_rd_d;
  logic [15:0] pair_rd_d;
  logic        carry_out_d;
  logic [7:0]  tbl_lo_q;
  logic [7:0]  tbl_lo_d;

  logic [1:0]  bank_sel;
  logic [7:0]  sel_reg;
  logic [15:0] acc_pair;
  logic [7:0]  acc;
  logic        rf_wr_en;
  logic [2:0]  rf_wr_code;
  logic [7:0]  rf_wr_data;
  logic        rf_pair_wr_en;
  logic [15:0] rf_pair_wr_data;

  logic [15:0] next_pc;
  logic [15:0] rel_ext;
  logic [15:0] rel_target;
  logic [15:0] fixed_target;
  logic [4:0]  tbl_index;
  logic [15:0] tbl_entry;
  logic [15:0] product;
  logic [15:0] quotient;
  logic [7:0]  remainder;
  logic [7:0]  adj_add;
  logic [7:0]  adj_sub;
  logic        adj_add_cy;
  logic        start;

  assign bank_sel = {bank_select_flag_high, bank_select_flag_low}; // RULE14
  assign acc      = acc_pair[15:8];
  assign start    = instr_valid && (st_q == bao_pkg::ST_IDLE);

  bao_regfile u_regfile (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .bank_sel     (bank_sel),
    .rd_code      (reg_code),
    .rd_data      (sel_reg),
    .pair_data    (acc_pair),
    .wr_en        (rf_wr_en),
    .wr_code      (rf_wr_code),
    .wr_data      (rf_wr_data),
    .pair_wr_en   (rf_pair_wr_en),
    .pair_wr_data (rf_pair_wr_data)
  );

  // Target arithmetic, all in 16 bits so wraparound drops the carry
  always_comb begin
    next_pc      = pc_q + {13'h0000, instr_len}; // RULE1
    rel_ext      = {{8{rel_displacement[bao_pkg::SIGN_BIT]}}, rel_displacement}; // RULE3 RULE16
    rel_target   = next_pc + rel_ext; // RULE2 RULE16
    fixed_target = bao_pkg::FIXED_BASE | {5'h00, eleven_bit_target}; // RULE6
    tbl_index    = opcode_byte[bao_pkg::IDX_MSB:bao_pkg::IDX_LSB]; // RULE7
    tbl_entry    = bao_pkg::TABLE_BASE + {10'h000, tbl_index, 1'b0}; // RULE8 RULE17
  end

  // Implied operand arithmetic on the accumulator
  always_comb begin
    product = 16'(acc) * 16'(sel_reg); // RULE10
    // Divide by zero gives all ones and keeps the low dividend byte as remainder
    if (sel_reg == 8'h00) begin
      quotient  = 16'hFFFF;
      remainder = acc_pair[7:0];
    end else begin
      quotient  = acc_pair / 16'(sel_reg); // RULE11
      remainder = 8'(acc_pair % 16'(sel_reg));
    end
    adj_add    = acc; // RULE12
    adj_add_cy = carry_flag;
    if (aux_carry_flag || acc[3:0] > bao_pkg::BCD_MAX_DIGIT) begin
      adj_add = adj_add + bao_pkg::BCD_LOW_FIX;
    end
    if (carry_flag || acc > bao_pkg::BCD_MAX_BYTE) begin
      adj_add    = adj_add + bao_pkg::BCD_HIGH_FIX;
      adj_add_cy = 1'b1;
    end
    adj_sub = acc; // RULE12
    if (aux_carry_flag) begin
      adj_sub = adj_sub - bao_pkg::BCD_LOW_FIX;
    end
    if (carry_flag) begin
      adj_sub = adj_sub - bao_pkg::BCD_HIGH_FIX;
    end
  end

  // Sequencing, program counter and operand writes
  always_comb begin
    st_d            = st_q;
    pc_d            = pc_q;
    busy_d          = busy_q;
    done_d          = 1'b0;
    push_ret_d      = 1'b0;
    ret_addr_d      = ret_addr_q;
    mem_rd_req_d    = mem_rd_req_q;
    mem_addr_d      = mem_addr_q;
    mem_wr_en_d     = 1'b0;
    mem_wr_data_d   = mem_wr_data_q;
    carry_out_d     = carry_out_q;
    tbl_lo_d        = tbl_lo_q;
    rf_wr_en        = 1'b0;
    rf_wr_code      = reg_code;
    rf_wr_data      = reg_wr_data;
    rf_pair_wr_en   = 1'b0;
    rf_pair_wr_data = product;
    reg_rd_d        = sel_reg;
    pair_rd_d       = acc_pair;
    unique case (st_q)
      bao_pkg::ST_IDLE: begin
        if (start) begin
          done_d = 1'b1;
          pc_d   = next_pc; // RULE1
          unique case (op_kind)
            bao_pkg::OP_BR_REL: begin
              pc_d = rel_target; // RULE4
            end
            bao_pkg::OP_BR_COND: begin
              pc_d = cond_true ? rel_target : next_pc; // RULE4
            end
            bao_pkg::OP_BR_ABS: begin
              pc_d = imm16; // RULE5
            end
            bao_pkg::OP_CALL_ABS: begin
              pc_d       = imm16; // RULE5
              push_ret_d = 1'b1;
              ret_addr_d = next_pc;
            end
            bao_pkg::OP_CALL_FIXED: begin
              pc_d       = fixed_target; // RULE6
              push_ret_d = 1'b1;
              ret_addr_d = next_pc;
            end
            bao_pkg::OP_CALL_TABLE: begin
              // Program counter holds until both table bytes have arrived
              pc_d         = pc_q;
              done_d       = 1'b0;
              busy_d       = 1'b1;
              ret_addr_d   = next_pc;
              mem_rd_req_d = 1'b1;
              mem_addr_d   = tbl_entry; // RULE8 RULE17
              st_d         = bao_pkg::ST_TBL_LO;
            end
            bao_pkg::OP_BR_PAIR: begin
              pc_d = acc_pair; // RULE9
            end
            bao_pkg::OP_UNSIGNED_MULTIPLY: begin
              rf_pair_wr_en   = 1'b1; // RULE10
              rf_pair_wr_data = product;
            end
            bao_pkg::OP_UNSIGNED_WORD_DIVIDE: begin
              rf_pair_wr_en   = 1'b1; // RULE11
              rf_pair_wr_data = quotient;
              rf_wr_en        = 1'b1;
              rf_wr_data      = remainder;
            end
            bao_pkg::OP_ADJ_ADD: begin
              rf_wr_en    = 1'b1;
              rf_wr_code  = bao_pkg::REG_A; // RULE12
              rf_wr_data  = adj_add;
              carry_out_d = adj_add_cy;
            end
            bao_pkg::OP_ADJ_SUB: begin
              rf_wr_en    = 1'b1;
              rf_wr_code  = bao_pkg::REG_A; // RULE12
              rf_wr_data  = adj_sub;
              carry_out_d = carry_flag;
            end
            bao_pkg::OP_ROT_LEFT: begin
              rf_wr_en      = 1'b1;
              rf_wr_code    = bao_pkg::REG_A; // RULE13
              rf_wr_data    = {acc[7:4], mem_operand[7:4]};
              mem_wr_en_d   = 1'b1;
              mem_wr_data_d = {mem_operand[3:0], acc[3:0]};
            end
            bao_pkg::OP_ROT_RIGHT: begin
              rf_wr_en      = 1'b1;
              rf_wr_code    = bao_pkg::REG_A; // RULE13
              rf_wr_data    = {acc[7:4], mem_operand[3:0]};
              mem_wr_en_d   = 1'b1;
              mem_wr_data_d = {acc[3:0], mem_operand[7:4]};
            end
            bao_pkg::OP_REG_WRITE: begin
              rf_wr_en = 1'b1; // RULE14
            end
            bao_pkg::OP_SEQ, bao_pkg::OP_NOP: begin
              pc_d = next_pc; // RULE1
            end
          endcase
        end
      end
      bao_pkg::ST_TBL_LO: begin
        if (mem_rd_valid) begin
          tbl_lo_d   = mem_rd_data; // RULE17
          mem_addr_d = mem_addr_q + 16'h0001;
          st_d       = bao_pkg::ST_TBL_HI;
        end
      end
      bao_pkg::ST_TBL_HI: begin
        if (mem_rd_valid) begin
          pc_d         = {mem_rd_data, tbl_lo_q}; // RULE8 RULE17
          mem_rd_req_d = 1'b0;
          busy_d       = 1'b0;
          done_d       = 1'b1;
          push_ret_d   = 1'b1;
          st_d         = bao_pkg::ST_IDLE;
        end
      end
      default: begin
        st_d         = bao_pkg::ST_IDLE;
        mem_rd_req_d = 1'b0;
        busy_d       = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q          <= bao_pkg::ST_IDLE;
      pc_q          <= bao_pkg::RESET_PC;
      busy_q        <= 1'b0;
      done_q        <= 1'b0;
      push_ret_q    <= 1'b0;
      ret_addr_q    <= 16'h0000;
      mem_rd_req_q  <= 1'b0;
      mem_addr_q    <= 16'h0000;
      mem_wr_en_q   <= 1'b0;
      mem_wr_data_q <= 8'h00;
      reg_rd_q      <= 8'h00;
      pair_rd_q     <= 16'h0000;
      carry_out_q   <= 1'b0;
      tbl_lo_q      <= 8'h00;
    end else begin
      st_q          <= st_d;
      pc_q          <= pc_d;
      busy_q        <= busy_d;
      done_q        <= done_d;
      push_ret_q    <= push_ret_d;
      ret_addr_q    <= ret_addr_d;
      mem_rd_req_q  <= mem_rd_req_d;
      mem_addr_q    <= mem_addr_d;
      mem_wr_en_q   <= mem_wr_en_d;
      mem_wr_data_q <= mem_wr_data_d;
      reg_rd_q      <= reg_rd_d;
      pair_rd_q     <= pair_rd_d;
      carry_out_q   <= carry_out_d;
      tbl_lo_q      <= tbl_lo_d;
    end
  end

endmodule // bao_core
`default_nettype wire

// *** shared/bao_pkg.sv ***
// Constants and types shared by the branch and operand addressing core.
// Assumes the fetch/decode logic supplies one decoded instruction at a time.
// Notes on behaviour
// [RULE1] Sequential flow moves the program counter on by the byte length of the instruction just fetched.
// [RULE2] A relative branch loads the start of the next instruction plus the displacement byte.
// [RULE3] The displacement byte is two's complement with bit 7 as sign, reaching -128 to +127.
// [RULE4] The unconditional short branch and every taken conditional branch use the relative target.
// [RULE5] Absolute call and branch load the 16-bit immediate straight into the program counter.
// [RULE6] The fixed-area call reaches only 0800H to 0FFFH from its eleven-bit target.
// [RULE7] The table call picks its entry with bits 1 to 5 of the opcode immediate.
// [RULE8] The table call reads its destination from the table at 0040H to 007FH and jumps there.
// [RULE9] The register-indirect branch copies the accumulator pair into the program counter.
// [RULE10] Unsigned multiply takes the accumulator times the selected register into the accumulator pair.
// [RULE11] Unsigned word divide takes its dividend from the accumulator pair and puts the quotient back there.
// [RULE12] Decimal adjust for add and subtract corrects the accumulator in place.
// [RULE13] Digit rotate left and right keep their four-bit digit data in the accumulator.
// [RULE14] A register operand is chosen by the bank select flags together with a 3-bit register code.
// [RULE15] Bank registers are X, A, C, B, E, D, L, H, pairing as AX, BC, DE and HL.
// [RULE16] The displacement is sign-extended to 16 bits and the carry out of bit 15 is dropped.
// [RULE17] The table entry lies at 0040H plus twice the index, low byte first then high byte.
package bao_pkg;

  localparam logic [15:0] RESET_PC       = 16'h0000;
  localparam logic [15:0] TABLE_BASE     = 16'h0040;
  localparam logic [15:0] TABLE_LAST     = 16'h007F;
  localparam logic [15:0] FIXED_BASE     = 16'h0800;
  localparam logic [15:0] FIXED_LAST     = 16'h0FFF;
  localparam int          FIXED_WIDTH    = 11;
  localparam int          IDX_LSB        = 1;
  localparam int          IDX_MSB        = 5;
  localparam int          SIGN_BIT       = 7;

  localparam logic [2:0]  REG_X          = 3'h0;
  localparam logic [2:0]  REG_A          = 3'h1;
  localparam logic [2:0]  REG_C          = 3'h2;
  localparam logic [2:0]  REG_B          = 3'h3;
  localparam logic [2:0]  REG_E          = 3'h4;
  localparam logic [2:0]  REG_D          = 3'h5;
  localparam logic [2:0]  REG_L          = 3'h6;
  localparam logic [2:0]  REG_H          = 3'h7;
  localparam int          NUM_BANKS      = 4;
  localparam int          REGS_PER_BANK  = 8;
  localparam logic [7:0]  REG_RESET      = 8'h00;

  localparam logic [3:0]  BCD_MAX_DIGIT  = 4'h9;
  localparam logic [7:0]  BCD_MAX_BYTE   = 8'h99;
  localparam logic [7:0]  BCD_LOW_FIX    = 8'h06;
  localparam logic [7:0]  BCD_HIGH_FIX   = 8'h60;

  typedef enum logic [3:0] {
    OP_SEQ        = 4'h0,
    OP_BR_REL     = 4'h1,
    OP_BR_COND    = 4'h2,
    OP_BR_ABS     = 4'h3,
    OP_CALL_ABS   = 4'h4,
    OP_CALL_FIXED = 4'h5,
    OP_CALL_TABLE = 4'h6,
    OP_BR_PAIR    = 4'h7,
    OP_UNSIGNED_MULTIPLY       = 4'h8,
    OP_UNSIGNED_WORD_DIVIDE      = 4'h9,
    OP_ADJ_ADD    = 4'hA,
    OP_ADJ_SUB    = 4'hB,
    OP_ROT_LEFT   = 4'hC,
    OP_ROT_RIGHT  = 4'hD,
    OP_REG_WRITE  = 4'hE,
    OP_NOP        = 4'hF
  } bao_op_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TBL_LO,
    ST_TBL_HI
  } bao_state_type;

endpackage

// *** hdl/bao_regfile.sv ***
// Banked general-purpose register file, four banks of eight bytes.
// Assumes one byte write and one accumulator-pair write per cycle at most.
`timescale 1ns/1ps
`default_nettype none
module bao_regfile (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  bank_sel,
  input  wire logic [2:0]  rd_code,
  output logic      [7:0]  rd_data,
  output logic      [15:0] pair_data,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_code,
  input  wire logic [7:0]  wr_data,
  input  wire logic        pair_wr_en,
  input  wire logic [15:0] pair_wr_data
);

  localparam int NUM_REGS = bao_pkg::NUM_BANKS * bao_pkg::REGS_PER_BANK;

  logic [7:0] regs_q [NUM_REGS];
  logic [7:0] regs_d [NUM_REGS];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      localparam logic [1:0] BANK = 2'(gi / bao_pkg::REGS_PER_BANK);
      localparam logic [2:0] CODE = 3'(gi % bao_pkg::REGS_PER_BANK);
      always_comb begin
        regs_d[gi] = regs_q[gi];
        // Pair write first so a byte write to A or X in the same cycle lands last
        if (pair_wr_en && bank_sel == BANK && CODE == bao_pkg::REG_X) begin
          regs_d[gi] = pair_wr_data[7:0];
        end
        if (pair_wr_en && bank_sel == BANK && CODE == bao_pkg::REG_A) begin
          regs_d[gi] = pair_wr_data[15:8];
        end
        if (wr_en && bank_sel == BANK && wr_code == CODE) begin // RULE14
          regs_d[gi] = wr_data;
        end
      end
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          regs_q[gi] <= bao_pkg::REG_RESET;
        end else begin
          regs_q[gi] <= regs_d[gi];
        end
      end
    end
  endgenerate

  assign rd_data   = regs_q[{bank_sel, rd_code}]; // RULE14
  assign pair_data = {regs_q[{bank_sel, bao_pkg::REG_A}], regs_q[{bank_sel, bao_pkg::REG_X}]}; // RULE15

endmodule // bao_regfile
`default_nettype wire

// *** bench/bao_core_chk.sv ***
// Concurrent checks on program counter formation and the table fetch of bao_core.
// Assumes it is bound to bao_core and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module bao_core_chk (
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic                instr_valid,
  input wire bao_pkg::bao_op_type op_kind,
  input wire logic [2:0]          instr_len,
  input wire logic [7:0]          opcode_byte,
  input wire logic [7:0]          rel_displacement,
  input wire logic [15:0]         imm16,
  input wire logic [10:0]         eleven_bit_target,
  input wire logic                cond_true,
  input wire logic [15:0]         pc_q,
  input wire logic                busy_q,
  input wire logic                done_q,
  input wire logic                mem_rd_req_q,
  input wire logic [15:0]         mem_addr_q,
  input wire logic                mem_rd_valid,
  input wire logic [7:0]          mem_rd_data,
  input wire logic [15:0]         pair_rd_q
);
  logic        take;
  logic [15:0] seq_tgt;
  logic [15:0] rel_tgt;
  logic [7:0]  lo_q;
  assign take    = instr_valid && !busy_q;
  assign seq_tgt = pc_q + {13'h0000, instr_len};
  assign rel_tgt = seq_tgt + {{8{rel_displacement[7]}}, rel_displacement};
  // Low table byte kept aside so the final jump can be tied to both reads
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_q <= 8'h00;
    end else if (mem_rd_valid && mem_rd_req_q && !mem_addr_q[0]) begin
      lo_q <= mem_rd_data;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_seq_advance: assert property (take && op_kind == bao_pkg::OP_SEQ |=> pc_q == $past(seq_tgt))
    else $error("sequential pc wrong");
  a_rel_target: assert property (take && op_kind == bao_pkg::OP_BR_REL |=> pc_q == $past(rel_tgt))
    else $error("relative target wrong");
  a_cond_branch: assert property (take && op_kind == bao_pkg::OP_BR_COND
    |=> pc_q == ($past(cond_true) ? $past(rel_tgt) : $past(seq_tgt))) else $error("conditional target wrong");
  a_abs_target: assert property (take && (op_kind == bao_pkg::OP_BR_ABS || op_kind == bao_pkg::OP_CALL_ABS)
    |=> pc_q == $past(imm16)) else $error("absolute target wrong");
  a_fixed_window: assert property (take && op_kind == bao_pkg::OP_CALL_FIXED
    |=> pc_q == {5'h01, $past(eleven_bit_target)}) else $error("fixed area target wrong");
  a_table_entry: assert property (take && op_kind == bao_pkg::OP_CALL_TABLE
    |=> mem_rd_req_q && busy_q && mem_addr_q == 16'h0040 + {10'h000, $past(opcode_byte[5:1]), 1'b0})
    else $error("table entry address wrong");
  a_table_load: assert property (mem_rd_valid && mem_rd_req_q && mem_addr_q[0]
    |=> done_q && !busy_q && pc_q == {$past(mem_rd_data), lo_q}) else $error("table destination wrong");
  a_table_hold: assert property (busy_q |=> done_q || $stable(pc_q))
    else $error("pc moved during table fetch");
  // The pair copy registered at the taking edge is the value the jump used
  a_pair_branch: assert property (take && op_kind == bao_pkg::OP_BR_PAIR |=> pc_q == pair_rd_q)
    else $error("pair branch target wrong");
endmodule // bao_core_chk
bind bao_core bao_core_chk i_chk (
  .core_clk, .rst_n, .instr_valid, .op_kind, .instr_len, .opcode_byte, .rel_displacement, .imm16,
  .eleven_bit_target, .cond_true, .pc_q, .busy_q, .done_q, .mem_rd_req_q, .mem_addr_q, .mem_rd_valid,
  .mem_rd_data, .pair_rd_q
);
`default_nettype wire

// *** bench/bao_mem_model.sv ***
// Program memory model answering the core's table reads after a settable wait.
// Assumes the core holds its read request and address until it takes a byte.
`timescale 1ns/1ps
`default_nettype none
module bao_mem_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  wait_cycles,
  input  wire logic        mem_rd_req_q,
  input  wire logic [15:0] mem_addr_q,
  output logic             mem_rd_valid,
  output logic      [7:0]  mem_rd_data
);
  logic [3:0] cnt_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q        <= 4'h0;
      mem_rd_valid <= 1'b0;
      mem_rd_data  <= 8'h00;
    end else if (mem_rd_req_q && !mem_rd_valid && cnt_q >= wait_cycles) begin
      cnt_q        <= 4'h0;
      mem_rd_valid <= 1'b1;
      mem_rd_data  <= mem_addr_q[7:0] ^ 8'hC5;
    end else begin
      cnt_q        <= (mem_rd_req_q && !mem_rd_valid) ? cnt_q + 4'h1 : 4'h0;
      mem_rd_valid <= 1'b0;
      // Idle bus toggles so a stale byte never looks fresh
      mem_rd_data  <= ~mem_rd_data;
    end
  end
endmodule // bao_mem_model
`default_nettype wire

// *** bench/bao_core_bench.sv ***
// Self-checking bench for bao_core with a program memory model on the table port.
// Assumes the shared package is compiled first and the checker is bound to the core.
`timescale 1ns/1ps
`default_nettype none
module bao_core_bench;
  typedef struct packed {
    bao_pkg::bao_op_type op;
    logic [2:0]          len;
    logic [7:0]          disp;
    logic [15:0]         imm;
    logic [10:0]         e11;
    logic                cond;
  } bao_row_type;
  logic        core_clk, rst_n, instr_valid, cond_true, carry_flag, aux_carry_flag;
  logic        bank_select_flag_low, bank_select_flag_high, busy_q, done_q, push_ret_q;
  logic        mem_rd_req_q, mem_rd_valid, mem_wr_en_q, carry_out_q;
  logic [2:0]  instr_len, reg_code;
  logic [3:0]  wait_cycles;
  logic [7:0]  opcode_byte, rel_displacement, reg_wr_data, mem_operand, mem_rd_data, mem_wr_data_q, reg_rd_q, wr_last;
  logic [10:0] eleven_bit_target;
  logic [15:0] imm16, pc_q, ret_addr_q, mem_addr_q, pair_rd_q, exp_pc;
  bao_pkg::bao_op_type op_kind;
  int          num_errors = 0, cmp_count = 0, cycles = 0;
  bao_row_type rows [12] = '{
    '{bao_pkg::OP_SEQ, 3'h1, 8'h00, 16'h0000, 11'h000, 1'b0}, '{bao_pkg::OP_SEQ, 3'h4, 8'h00, 16'h0000, 11'h000, 1'b0},
    '{bao_pkg::OP_BR_REL, 3'h2, 8'h7F, 16'h0000, 11'h000, 1'b0}, '{bao_pkg::OP_BR_REL, 3'h2, 8'h80, 16'h0000, 11'h000, 1'b0},
    '{bao_pkg::OP_BR_COND, 3'h3, 8'hF0, 16'h0000, 11'h000, 1'b1}, '{bao_pkg::OP_BR_COND, 3'h3, 8'h10, 16'h0000, 11'h000, 1'b0},
    '{bao_pkg::OP_CALL_FIXED, 3'h2, 8'h00, 16'h0000, 11'h7FF, 1'b0}, '{bao_pkg::OP_CALL_FIXED, 3'h2, 8'h00, 16'h0, 11'h000, 1'b0},
    '{bao_pkg::OP_BR_ABS, 3'h3, 8'h00, 16'hFFFC, 11'h000, 1'b0}, '{bao_pkg::OP_BR_REL, 3'h2, 8'h05, 16'h0000, 11'h000, 1'b0},
    '{bao_pkg::OP_CALL_ABS, 3'h3, 8'h00, 16'h1234, 11'h000, 1'b0}, '{bao_pkg::OP_SEQ, 3'h3, 8'h00, 16'h0000, 11'h000, 1'b0}};
  bao_core i_dut (
    .core_clk, .rst_n, .instr_valid, .op_kind, .instr_len, .opcode_byte, .rel_displacement, .imm16, .eleven_bit_target,
    .cond_true, .reg_code, .reg_wr_data, .bank_select_flag_low, .bank_select_flag_high, .carry_flag, .aux_carry_flag,
    .mem_operand, .pc_q, .busy_q, .done_q, .push_ret_q, .ret_addr_q, .mem_rd_req_q, .mem_addr_q, .mem_rd_valid,
    .mem_rd_data, .mem_wr_en_q, .mem_wr_data_q, .reg_rd_q, .pair_rd_q, .carry_out_q);
  bao_mem_model i_mem (.core_clk, .rst_n, .wait_cycles, .mem_rd_req_q, .mem_addr_q, .mem_rd_valid, .mem_rd_data);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (mem_wr_en_q === 1'b1) wr_last <= mem_wr_data_q;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] next_pc(input bao_row_type r, input logic [15:0] pc);
    logic [15:0] seq;
    seq = pc + {13'h0000, r.len};
    case (r.op)
      bao_pkg::OP_BR_REL:     next_pc = seq + {{8{r.disp[7]}}, r.disp};
      bao_pkg::OP_BR_COND:    next_pc = r.cond ? seq + {{8{r.disp[7]}}, r.disp} : seq;
      bao_pkg::OP_BR_ABS,
      bao_pkg::OP_CALL_ABS:   next_pc = r.imm;
      bao_pkg::OP_CALL_FIXED: next_pc = 16'h0800 + {5'h00, r.e11};
      default:                next_pc = seq;
    endcase
  endfunction
  task automatic run(input bao_pkg::bao_op_type op, input logic [2:0] code, input logic [7:0] wd, input logic [1:0] bk);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    op_kind <= op;
    reg_code <= code;
    reg_wr_data <= wd;
    {bank_select_flag_high, bank_select_flag_low} <= bk;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // A second offer while busy must be dropped; it is lowered before the fetch can end
  task automatic table_call(input logic [4:0] idx, input logic [3:0] dly);
    logic [7:0]  ent;
    logic [15:0] ret;
    ent = 8'h40 + {2'h0, idx, 1'b0};
    ret = pc_q + {13'h0000, instr_len};
    @(posedge core_clk);
    wait_cycles <= dly;
    instr_valid <= 1'b1;
    op_kind <= bao_pkg::OP_CALL_TABLE;
    opcode_byte <= {2'h0, idx, 1'b0};
    @(posedge core_clk);
    op_kind <= bao_pkg::OP_BR_ABS;
    @(negedge core_clk);
    cmp(16'(busy_q), 16'h0001);
    @(posedge core_clk);
    instr_valid <= 1'b0;
    for (int n = 0; n < 40 && done_q !== 1'b1; n++) @(negedge core_clk);
    cmp(pc_q, {(ent + 8'h01) ^ 8'hC5, ent ^ 8'hC5});
    cmp({15'h0000, push_ret_q}, 16'h0001);
    cmp(ret_addr_q, ret);
    $display("table call %0d done", idx);
  endtask
  initial begin
    {rst_n, instr_valid, cond_true, carry_flag, aux_carry_flag, bank_select_flag_low, bank_select_flag_high} = '0;
    {instr_len, reg_code, wait_cycles, opcode_byte, rel_displacement, reg_wr_data, eleven_bit_target, imm16} = '0;
    op_kind = bao_pkg::OP_NOP;
    mem_operand = 8'h5A;
    exp_pc = 16'h0000;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i <= 12; i++) begin
      @(posedge core_clk);
      instr_valid <= (i < 12);
      if (i < 12) begin
        op_kind <= rows[i].op;
        instr_len <= rows[i].len;
        rel_displacement <= rows[i].disp;
        imm16 <= rows[i].imm;
        eleven_bit_target <= rows[i].e11;
        cond_true <= rows[i].cond;
      end
      @(negedge core_clk);
      if (i > 0) cmp(pc_q, exp_pc);
      if (i < 12) exp_pc = next_pc(rows[i], exp_pc);
    end
    $display("pc rows done");
    for (int b = 0; b < 4; b++)
      for (int c = 0; c < 8; c++) run(bao_pkg::OP_REG_WRITE, 3'(c), 8'(b * 16 + c + 32), 2'(b));
    for (int b = 0; b < 4; b++)
      for (int c = 0; c < 8; c++) begin
        run(bao_pkg::OP_NOP, 3'(c), 8'h00, 2'(b));
        cmp(16'(reg_rd_q), 16'(b * 16 + c + 32));
      end
    run(bao_pkg::OP_NOP, 3'h0, 8'h00, 2'h2);
    cmp(pair_rd_q, 16'h4140);
    run(bao_pkg::OP_BR_PAIR, 3'h0, 8'h00, 2'h2);
    cmp(pc_q, 16'h4140);
    run(bao_pkg::OP_UNSIGNED_MULTIPLY, 3'h2, 8'h00, 2'h2);
    cmp(pair_rd_q, 16'h0041 * 16'h0042);
    run(bao_pkg::OP_UNSIGNED_WORD_DIVIDE, 3'h3, 8'h00, 2'h2);
    cmp(pair_rd_q, (16'h0041 * 16'h0042) / 16'h0043);
    cmp(16'(reg_rd_q), (16'h0041 * 16'h0042) % 16'h0043);
    $display("register tests done");
    run(bao_pkg::OP_REG_WRITE, 3'h1, 8'h3C, 2'h2);
    run(bao_pkg::OP_ADJ_ADD, 3'h1, 8'h00, 2'h2);
    cmp({reg_rd_q, 7'h00, carry_out_q}, 16'h4200);
    @(posedge core_clk);
    carry_flag <= 1'b1;
    aux_carry_flag <= 1'b1;
    run(bao_pkg::OP_ADJ_SUB, 3'h1, 8'h00, 2'h2);
    cmp({reg_rd_q, 7'h00, carry_out_q}, 16'hDC01);
    run(bao_pkg::OP_ROT_LEFT, 3'h1, 8'h00, 2'h2);
    cmp({reg_rd_q, wr_last}, 16'hD5AC);
    run(bao_pkg::OP_ROT_RIGHT, 3'h1, 8'h00, 2'h2);
    cmp({reg_rd_q, wr_last}, 16'hDA55);
    $display("implied operand tests done");
    table_call(5'h1F, 4'h3);
    table_call(5'h00, 4'h0);
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(negedge core_clk);
    cmp(pc_q, 16'h0000);
    cmp(pair_rd_q, 16'h0000);
    @(posedge core_clk);
    rst_n <= 1'b1;
    run(bao_pkg::OP_NOP, 3'h1, 8'h00, 2'h2);
    cmp(16'(reg_rd_q), 16'h0000);
    $display("reset test done");
    report_and_stop();
  end
endmodule // bao_core_bench
`default_nettype wire
